// ===== design/sps_params.svh
// Purpose: constants of the serial register port
// Assumes: 16-bit command words, mode 0
// Notes:   included by both ends
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
`define SPS_WORD_BITS      16
`define SPS_OPC_MSB        15
`define SPS_OPC_LSB        12
`define SPS_HWA_MSB        11
`define SPS_HWA_LSB        8
`define SPS_BCAST_BIT      12
`define SPS_HWA_RESET      4'h0
`define SPS_OP_SET_ADDR    3'h4
`define SPS_OP_WRITE_BYTE  3'h5
`define SPS_OP_READ_LOW    3'h6
`define SPS_OP_READ_HIGH   3'h7
`define SPS_CMD_SET_ADDR   16'h8000
`define SPS_CMD_WRITE_BYTE 16'hA000
`define SPS_CMD_READ_LOW   16'hC000
`define SPS_CMD_READ_HIGH  16'hE000
`define SPS_CMD_NOP        16'h0000
`define SPS_CMD_LATCH_HWA  16'hF0FF
`define SPS_SYNC_DEFAULT   5'h00
`define SPS_SYNC_PHASE     5'h04
`define SPS_SCK_HALF       8
`endif

// ===== design/sps_pkg.sv
// Purpose: shared types of the serial register port
// Assumes: nothing
// Notes:   constants live in sps_params.svh
package sps_pkg;
   typedef enum logic [1:0] {SPS_IDLE, SPS_WAIT, SPS_READY} sps_rd_state_t;
   typedef enum logic [1:0] {SPH_IDLE, SPH_SHIFT, SPH_GAP} sps_host_state_t;
endpackage

// ===== design/sps_if.sv
// Purpose: serial link between host and device
// Assumes: tri-state data output with pull-up
// Notes:   the wire level of miso is resolved here
`timescale 1ns/10ps
interface sps_if;
   logic sck;
   logic select_enable_in;
   logic mosi;
   logic miso_o;
   logic miso_oe;
   logic miso;
   assign miso = miso_oe ? miso_o : 1'b1;
   modport device (input sck, select_enable_in, mosi, output miso_o, miso_oe);
   modport host   (output sck, select_enable_in, mosi, input miso);
endinterface

// ===== design/sps_device.sv
// Purpose: device end of the serial register port
// Assumes: link pins sampled by CLOCK_I; sck well below CLOCK_I/4
// Notes:   register map is outside; reached through REG_* ports
// Behaviour
// R1: Sample mosi on sck rising edge
// R2: Change miso on sck falling edge
// R3: Active while select low, else wait/float
// R4: Execute command on select rising edge
// R5: Miso low during reset and sync wait
// R6: Host keeps select high while waiting
// R7: Opcode, hardware address, data fields
// R8: Set-address, write, low read encodings
// R9: High read and no-operation encodings
// R10: Broadcast flag active low skips address check
// R11: Accept only matching hardware address
// R12: Address zero at reset, latch from pins
// R13: Read result shifted out regardless of address
// R14: Low read loads holding, sends low half
// R15: High read sends upper half
// R16: Host chains low/high reads then no-op
// R17: Write is address set then data byte
// R18: Sync load offset by sync field, miso low
// R19: Read_bit_a bit loads holding immediately
// R20: Software picks sync offset per register
// R21: Mode 0, 16-bit words, MSB first
// R22: Port selected if select high at reset
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_device
   import sps_pkg::*;
(
   input  wire logic        CLOCK_I,
   input  wire logic        RST_N_I,
   input  wire logic        CE_I,
   sps_if.device            LINK,
   input  wire logic [3:0]  HW_ADDRESS_PINS_I,
   input  wire logic        READ_BIT_A_I,
   input  wire logic [4:0]  SYNC_OFFSET_I,
   input  wire logic        SAMPLE_TICK_I,
   output logic       [7:0] REG_ADDR_O,
   output logic       [7:0] REG_WDATA_O,
   output logic             REG_WE_O,
   input  wire logic [31:0] REG_RDATA_I,
   output logic             PORT_ACTIVE_O
);
   logic [2:0]  sck_s_q, sck_s_d, sen_s_q, sen_s_d, mosi_s_q, mosi_s_d;
   logic [15:0] shift_q, shift_d, tx_q, tx_d;
   logic [31:0] hold_q, hold_d;
   logic [7:0]  addr_q, addr_d, wdata_q, wdata_d;
   logic [3:0]  hwa_q, hwa_d;
   logic [4:0]  dly_q, dly_d;
   logic        we_q, we_d, active_q, active_d, out_q, out_d;
   logic [1:0]  strap_q, strap_d;
   logic [3:0]  hwp1_q, hwp1_d, hwp2_q, hwp2_d;
   sps_rd_state_t rd_q, rd_d;
   logic        sck_rise, sck_fall, sen_rise, sen_fall, sen_lvl;
   logic        match, is_cmd;
   logic [2:0]  op;

   assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
   assign sck_fall = ~sck_s_q[1] & sck_s_q[2];
   assign sen_rise = sen_s_q[1] & ~sen_s_q[2];
   assign sen_fall = ~sen_s_q[1] & sen_s_q[2];
   assign sen_lvl  = sen_s_q[1];
   assign op       = shift_q[`SPS_OPC_MSB:13];
   assign is_cmd   = shift_q[`SPS_OPC_MSB];                                   // R9
   // Broadcast skips the address compare; reads ignore the bit entirely
   assign match    = ~shift_q[`SPS_BCAST_BIT] | (shift_q[`SPS_HWA_MSB:`SPS_HWA_LSB] == hwa_q); // R10 R11

   always_comb begin
      sck_s_d  = {sck_s_q[1:0], LINK.sck};
      sen_s_d  = {sen_s_q[1:0], LINK.select_enable_in};
      mosi_s_d = {mosi_s_q[1:0], LINK.mosi};
      shift_d  = shift_q;
      tx_d     = tx_q;
      hold_d   = hold_q;
      addr_d   = addr_q;
      wdata_d  = wdata_q;
      hwa_d    = hwa_q;
      dly_d    = dly_q;
      we_d     = 1'b0;
      rd_d     = rd_q;
      out_d    = out_q;
      strap_d  = (strap_q == 2'h0) ? 2'h0 : strap_q - 2'h1;
      hwp1_d   = HW_ADDRESS_PINS_I;
      hwp2_d   = hwp1_q;
      active_d = active_q;
      // Wait until the select synchroniser holds a real pin sample, not its reset value
      if (strap_q == 2'h1) begin
         active_d = sen_lvl;                                                 // R22
      end
      if (active_q && !sen_lvl && sck_rise) begin
         shift_d = {shift_q[14:0], mosi_s_q[1]};                             // R1 R21
      end
      if (active_q && !sen_lvl && sck_fall) begin
         out_d = tx_q[15];                                                   // R2
         tx_d  = {tx_q[14:0], 1'b0};
      end
      if (sen_fall) begin
         out_d = tx_q[15];
         tx_d  = {tx_q[14:0], 1'b0};
      end
      if (active_q && sen_rise && is_cmd) begin                              // R4
         if (shift_q == `SPS_CMD_LATCH_HWA) begin
            hwa_d = hwp2_q;                                                  // R12
         end else begin
            case (op)
               `SPS_OP_SET_ADDR: begin
                  if (match) addr_d = shift_q[7:0];                          // R8 R17
               end
               `SPS_OP_WRITE_BYTE: begin
                  if (match) begin
                     wdata_d = shift_q[7:0];                                 // R17
                     we_d    = 1'b1;
                  end
               end
               `SPS_OP_READ_LOW: begin
                  if (shift_q[`SPS_HWA_MSB:`SPS_HWA_LSB] == hwa_q) begin     // R11
                     addr_d = {shift_q[7:2], 2'b00};                         // R8
                     dly_d  = SYNC_OFFSET_I;
                     rd_d   = READ_BIT_A_I ? SPS_READY : SPS_WAIT;           // R18 R19
                  end
               end
               `SPS_OP_READ_HIGH: begin
                  tx_d = hold_q[31:16];                                      // R15 R13
               end
               default: begin
               end
            endcase
         end
      end
      case (rd_q)
         SPS_WAIT: begin
            if (SAMPLE_TICK_I) begin
               if (dly_q == 5'h00) rd_d = SPS_READY;                         // R18
               else dly_d = dly_q - 5'h01;
            end
         end
         SPS_READY: begin
            hold_d = REG_RDATA_I;                                            // R14
            tx_d   = REG_RDATA_I[15:0];                                      // R14 R13
            rd_d   = SPS_IDLE;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         sck_s_q  <= 3'h0;
         sen_s_q  <= 3'h7;
         mosi_s_q <= 3'h0;
         shift_q  <= 16'h0000;
         tx_q     <= 16'h0000;
         hold_q   <= 32'h00000000;
         addr_q   <= 8'h00;
         wdata_q  <= 8'h00;
         hwa_q    <= `SPS_HWA_RESET;                                         // R12
         dly_q    <= 5'h00;
         we_q     <= 1'b0;
         rd_q     <= SPS_IDLE;
         out_q    <= 1'b0;
         active_q <= 1'b0;
         strap_q  <= 2'h3;
         hwp1_q   <= 4'h0;
         hwp2_q   <= 4'h0;
      end else if (CE_I) begin
         sck_s_q  <= sck_s_d;
         sen_s_q  <= sen_s_d;
         mosi_s_q <= mosi_s_d;
         shift_q  <= shift_d;
         tx_q     <= tx_d;
         hold_q   <= hold_d;
         addr_q   <= addr_d;
         wdata_q  <= wdata_d;
         hwa_q    <= hwa_d;
         dly_q    <= dly_d;
         we_q     <= we_d;
         rd_q     <= rd_d;
         out_q    <= out_d;
         active_q <= active_d;
         strap_q  <= strap_d;
         hwp1_q   <= hwp1_d;
         hwp2_q   <= hwp2_d;
      end
   end

   // Pulling low during reset and sync wait tells the host to hold off
   always_comb begin
      if (!RST_N_I || strap_q != 2'h0 || (active_q && rd_q != SPS_IDLE)) begin
         LINK.miso_o  = 1'b0;                                                // R5
         LINK.miso_oe = 1'b1;
      end else if (active_q && !sen_lvl) begin
         LINK.miso_o  = out_q;                                               // R3
         LINK.miso_oe = 1'b1;
      end else begin
         LINK.miso_o  = 1'b1;                                                // R3
         LINK.miso_oe = 1'b0;
      end
   end

   assign REG_ADDR_O    = addr_q;
   assign REG_WDATA_O   = wdata_q;
   assign REG_WE_O      = we_q;
   assign PORT_ACTIVE_O = active_q;
endmodule // sps_device

// ===== design/sps_host.sv
// Purpose: host end, sends one 16-bit word per software write
// Assumes: plain register port; sck made by divider
// Notes:   0x0 word reg, 0x4 status, 0x8 last received word
`timescale 1ns/10ps
`include "sps_params.svh"
module sps_host
   import sps_pkg::*;
(
   input  wire logic        CLOCK_I,
   input  wire logic        RST_N_I,
   input  wire logic        CE_I,
   sps_if.host              LINK,
   input  wire logic        DEVICE_RESET_N_I,
   input  wire logic [7:0]  ADDR_I,
   input  wire logic [15:0] WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output logic      [15:0] RDATA_O
);
   logic [2:0]  miso_s_q, miso_s_d;
   logic [15:0] tx_q, tx_d, rx_q, rx_d, rdata_q, rdata_d;
   logic [4:0]  bit_q, bit_d;
   logic [3:0]  div_q, div_d;
   logic        sck_q, sck_d, sen_q, sen_d, pend_q, pend_d;
   sps_host_state_t st_q, st_d;
   logic        ready;

   // Hold off while device is in reset or signals wait
   assign ready = DEVICE_RESET_N_I & miso_s_q[1];                            // R6

   always_comb begin
      miso_s_d = {miso_s_q[1:0], LINK.miso};
      tx_d = tx_q; rx_d = rx_q; bit_d = bit_q; div_d = div_q;
      sck_d = sck_q; sen_d = sen_q; pend_d = pend_q; st_d = st_q;
      rdata_d = 16'h0000;
      if (WR_I && ADDR_I == 8'h00) begin
         tx_d = WDATA_I;                                                     // R7 R16 R17
         pend_d = 1'b1;
      end
      if (RD_I) begin
         case (ADDR_I)
            8'h04:   rdata_d = {13'h0000, ready, pend_q, st_q != SPH_IDLE};
            8'h08:   rdata_d = rx_q;
            default: rdata_d = 16'h0000;
         endcase
      end
      case (st_q)
         SPH_IDLE: begin
            if (pend_q && ready && st_q == SPH_IDLE) begin
               sen_d = 1'b0; bit_d = 5'h00; div_d = 4'h0; st_d = SPH_SHIFT;
            end
         end
         SPH_SHIFT: begin
            div_d = div_q + 4'h1;
            if (div_q == 4'(`SPS_SCK_HALF - 1)) begin
               div_d = 4'h0;
               sck_d = ~sck_q;
               if (!sck_q) begin
                  rx_d = {rx_q[14:0], miso_s_q[1]};                          // R21
               end else begin
                  tx_d  = {tx_q[14:0], 1'b0};
                  bit_d = bit_q + 5'h01;
                  if (bit_q == 5'h0F) st_d = SPH_GAP;
               end
            end
         end
         SPH_GAP: begin
            div_d = div_q + 4'h1;
            if (div_q == 4'(`SPS_SCK_HALF - 1)) begin
               sen_d = 1'b1; pend_d = 1'b0; st_d = SPH_IDLE; div_d = 4'h0;
            end
         end
         default: st_d = SPH_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         miso_s_q <= 3'h0; tx_q <= 16'h0000; rx_q <= 16'h0000;
         rdata_q <= 16'h0000; bit_q <= 5'h00; div_q <= 4'h0;
         sck_q <= 1'b0; sen_q <= 1'b1; pend_q <= 1'b0; st_q <= SPH_IDLE;
      end else if (CE_I) begin
         miso_s_q <= miso_s_d; tx_q <= tx_d; rx_q <= rx_d;
         rdata_q <= rdata_d; bit_q <= bit_d; div_q <= div_d;
         sck_q <= sck_d; sen_q <= sen_d; pend_q <= pend_d; st_q <= st_d;
      end
   end

   assign LINK.sck              = sck_q;
   assign LINK.select_enable_in = sen_q;
   assign LINK.mosi             = tx_q[15];
   assign RDATA_O               = rdata_q;
endmodule // sps_host

// ===== tb/sps_assertions.sv
// Purpose: wire-level checks between host and device ends
// Assumes: one clock domain, sck sampled by CLOCK_I
// Notes:   bit counter is helper logic, cleared while deselected
`timescale 1ns/10ps
module sps_assertions (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic sck,
   input wire logic select_enable_in,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic miso
);
   logic       sck_q;
   logic [4:0] bits_q;
   logic [4:0] bits_d;
   always_comb begin
      bits_d = bits_q;
      if (select_enable_in) begin
         bits_d = 5'h00;
      end else if (sck && !sck_q) begin
         bits_d = bits_q + 5'h01;
      end
   end
   always_ff @(posedge CLOCK_I) begin
      sck_q  <= RST_N_I ? sck : 1'b0;
      bits_q <= RST_N_I ? bits_d : 5'h00;
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_high_half;
      sck [*8] ##1 !sck;
   endsequence
   AST_SCK_IDLE: assert property (select_enable_in |-> !sck) else $error("sck moves outside a frame");
   AST_SCK_HALF: assert property ($rose(sck) |-> s_high_half) else $error("sck high phase wrong");
   AST_MOSI_HOLD: assert property (sck && $past(sck) |-> $stable(mosi)) else $error("mosi moved while sck high");
   AST_MISO_HOLD: assert property (!select_enable_in && sck && $past(sck) |-> $stable(miso_o))
      else $error("miso moved while sck high");
   AST_OE_SELECTED: assert property ((!select_enable_in) [*4] |-> miso_oe) else $error("miso undriven in frame");
   AST_RESET_WAIT: assert property ($rose(RST_N_I) |-> !miso) else $error("miso not low in reset");
   AST_SELECT_AT_RESET: assert property ($rose(RST_N_I) |-> select_enable_in) else $error("select low in reset");
   AST_FRAME_BITS: assert property ($rose(select_enable_in) |-> bits_q == 5'h10) else $error("frame not 16 bits");
   AST_NO_SELECT_IN_WAIT: assert property ($fell(select_enable_in) |-> $past(miso))
      else $error("select fell during wait");
   AST_WAIT_BOUNDED: assert property ($rose(select_enable_in) |-> ##[1:600] miso) else $error("wait never ends");
endmodule // sps_assertions

// ===== tb/spi_slave_register_port_bench.sv
// Purpose: host and device ends face to face, checked against a byte model
// Assumes: register map is a byte array beside the device
// Notes:   read results are taken from the host's received word
`timescale 1ns/10ps
`include "sps_params.svh"
module spi_slave_register_port_bench;
   logic        clk;
   logic        rst_n;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic [3:0]  hw_pins;
   logic        read_bit_a_rd;
   logic [4:0]  sync_off;
   logic        tick;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_we;
   logic        active;
   logic [31:0] reg_rdata;
   logic [15:0] got;
   logic [3:0]  hf;
   logic [7:0]  mem [256];
   logic [7:0]  ref_mem [256];
   integer      bad_count, checked, seed, cycles, hw, ptr, i, r, b;
   sps_if link ();
   assign reg_rdata = {mem[reg_addr + 8'h03], mem[reg_addr + 8'h02], mem[reg_addr + 8'h01], mem[reg_addr]};
   sps_host i_sps_host (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .LINK(link.host), .DEVICE_RESET_N_I(rst_n),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
   sps_device i_sps_device (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .LINK(link.device),
      .HW_ADDRESS_PINS_I(hw_pins), .READ_BIT_A_I(read_bit_a_rd), .SYNC_OFFSET_I(sync_off), .SAMPLE_TICK_I(tick),
      .REG_ADDR_O(reg_addr), .REG_WDATA_O(reg_wdata), .REG_WE_O(reg_we), .REG_RDATA_I(reg_rdata),
      .PORT_ACTIVE_O(active));
   sps_assertions i_sps_assertions (.CLOCK_I(clk), .RST_N_I(rst_n), .sck(link.sck),
      .select_enable_in(link.select_enable_in), .mosi(link.mosi), .miso_o(link.miso_o),
      .miso_oe(link.miso_oe), .miso(link.miso));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic report_and_stop();
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checked = checked + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Sends one word, waits for the link to settle, then updates the model
   task automatic send(input logic [15:0] w);
      logic [15:0] s;
      bus_wr(8'h00, w);
      for (int k = 0; k < 3000; k++) begin
         bus_rd(8'h04, s);
         if (s[2:0] === 3'b100) break;
      end
      bus_rd(8'h08, got);
      if (w == `SPS_CMD_LATCH_HWA) hw = hw_pins;
      else if (w[15:13] == `SPS_OP_SET_ADDR && (!w[12] || w[11:8] == hw)) ptr = w[7:0];
      else if (w[15:13] == `SPS_OP_WRITE_BYTE && (!w[12] || w[11:8] == hw)) ref_mem[ptr] = w[7:0];
   endtask
   // Tick every 20 clocks keeps synchronous waits short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      tick   <= (cycles % 20) == 19;
      if (reg_we === 1'b1) mem[reg_addr] <= reg_wdata;
      if (cycles == 90000) begin
         bad_count = bad_count + 1;
         report_and_stop();
      end
   end
   initial begin
      seed = 56102;
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      hw_pins = 4'h0;
      read_bit_a_rd = 1'b1;
      sync_off = 5'h00;
      tick = 1'b0;
      bad_count = 0;
      checked = 0;
      cycles = 0;
      hw = 0;
      ptr = 0;
      for (i = 0; i < 256; i++) begin
         mem[i] = 8'($random(seed));
         ref_mem[i] = mem[i];
      end
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk("port_active", 32'h1, active);
      for (r = 0; r < 6; r++) begin
         read_bit_a_rd <= r[0];
         sync_off <= r[1] ? `SPS_SYNC_PHASE : `SPS_SYNC_DEFAULT;
         if (r == 2) begin
            hw_pins <= 4'($random(seed)) | 4'h1;
            send(`SPS_CMD_LATCH_HWA);
         end
         b = $random(seed) & 32'hFC;
         for (i = 0; i < 4; i++) begin
            hf = r[1] ? 4'(hw) : 4'($random(seed));
            send({3'b100, r[0], hf, 8'(b + i)});
            send({3'b101, r[0], hf, 8'($random(seed))});
         end
         send(`SPS_CMD_READ_LOW | {4'h0, 4'(hw), 8'(b)});
         send(`SPS_CMD_READ_HIGH | {4'h0, 12'($random(seed))});
         chk("low_half", {ref_mem[b + 1], ref_mem[b]}, got);
         send(`SPS_CMD_READ_LOW | {4'h0, 4'(hw), 8'(b)});
         chk("high_half", {ref_mem[b + 3], ref_mem[b + 2]}, got);
         send(`SPS_CMD_READ_HIGH);
         chk("low_half", {ref_mem[b + 1], ref_mem[b]}, got);
         send({1'b0, 15'($random(seed))});
         chk("high_half", {ref_mem[b + 3], ref_mem[b + 2]}, got);
      end
      for (i = 0; i < 256; i++) chk("reg_byte", 32'(ref_mem[i]), 32'(mem[i]));
      report_and_stop();
   end
endmodule // spi_slave_register_port_bench
